// ==== design/rtca_pkg.sv ====
// Package of constants and carrier types for the real time clock block
package rtca_pkg;

	localparam int          TB_HZ           = 32768;
	localparam logic [16:0] SEC_MAX         = 17'h1517F;
	localparam logic [16:0] SEC_RST         = 17'h00000;
	localparam logic [14:0] DAY_RST         = 15'h0000;
	localparam logic [16:0] ALARM_SEC_RST   = 17'h1FFFF;
	localparam logic [14:0] ALARM_DAY_RST   = 15'h7FFF;
	localparam logic [15:0] DIV_BASE        = 16'h8000;
	localparam logic [4:0]  CAL_RST         = 5'h00;
	localparam int          TICK_DIV_CYCLES = 250000000 / TB_HZ;
	localparam logic [12:0] TICK_DIV_LAST   = 13'(TICK_DIV_CYCLES - 1);

	typedef enum logic [1:0] {
		RTCA_CAL_OFF  = 2'b00,
		RTCA_CAL_MAIN = 2'b01,
		RTCA_CAL_RSVD = 2'b10,
		RTCA_CAL_ALL  = 2'b11
	} rtca_cal_mode_t;

	typedef enum logic [1:0] {
		RTCA_PWR_OFF,
		RTCA_PWR_LOW,
		RTCA_PWR_ON
	} rtca_pwr_t;

	typedef struct packed {
		logic [16:0] seconds;
		logic [14:0] day;
	} rtca_time_t;

	typedef struct packed {
		logic [4:0]     word;
		rtca_cal_mode_t mode;
	} rtca_cal_t;

endpackage

// ==== design/rtca_sync.sv ====
// Two flip-flop synchroniser for one level
`timescale 1ns/1ps
module rtca_sync import rtca_pkg::*; (
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic d_in,
	output logic      q_out
);
	logic meta;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta  <= 1'b0;
			q_out <= 1'b0;
		end else begin
			meta  <= d_in;
			q_out <= meta;
		end
	end
endmodule // rtca_sync

// ==== design/rtca_divider.sv ====
// Calibrated divider from time base enable to one-second tick
`timescale 1ns/1ps
module rtca_divider import rtca_pkg::*; (
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       step_in,
	input  wire logic       run_in,
	input  wire logic       cal_on_in,
	input  wire logic [4:0] cal_word_in,
	output logic            tick_out
);
	logic [15:0] count;
	logic [15:0] next_count;
	logic        next_tick;
	logic [15:0] terminal;

	always_comb begin
		// Period is 32768 plus the signed word when active
		terminal = cal_on_in ?
			16'(DIV_BASE + {{11{cal_word_in[4]}}, cal_word_in} - 16'h0001) :
			16'(DIV_BASE - 16'h0001);
		next_count = count;
		next_tick  = 1'b0;
		if (!run_in) begin
			next_count = 16'h0000;
		end else if (step_in) begin
			if (count >= terminal) begin
				next_count = 16'h0000;
				next_tick  = 1'b1;
			end else begin
				next_count = 16'(count + 16'h0001);
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count    <= 16'h0000;
			tick_out <= 1'b0;
		end else begin
			count    <= next_count;
			tick_out <= next_tick;
		end
	end
endmodule // rtca_divider

// ==== design/rtca_core.sv ====
// Real time clock: counters, alarm, calibration and keepalive outputs
//
// Contract
// - Keepalive set: processor clock output stays enabled in every state.
// - Keepalive clear: processor clock output not maintained in Off state.
// - Secure clock supply enabled right after clock reset; never disabled.
// - Writing one to clock disable bit stops the clock; default runs.
// - Time base is divided to a one-second tick advancing seconds.
// - Seconds counter is 17 bits, counts 0 to 86399, then wraps.
// - Each seconds wrap increments the 15-bit day counter.
// - Every tick sets one-second flag unless a time write falls in the same cycle; interrupt only while unmasked.
// - Alarm flag set when seconds and day equal alarm values.
// - Unmasked alarm turns on when off, interrupts when on.
// - Alarm mask resets to one.
// - Alarm seconds and day values load all ones at first power.
// - Alarm flag is retained on backup power.
// - Backup undervoltage resets counters, retained state, sets lost flag.
// - Only one alarm pair exists.
// - Five-bit two's-complement word trims the 32768-count divider.
// - Word adds or removes that many counts per 32768.
// - Calibration touches only the tick divider, not clock outputs.
// - Mode 00 off, 01 except backup-only, 11 always, 10 reserved.
// - Mode 01 disables calibration on battery loss or backup switchover.
`timescale 1ns/1ps
module rtca_core import rtca_pkg::*; (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        clock_power_on_reset_n_in,
	input  wire logic        main_battery_ok_in,
	input  wire logic        backup_only_in,
	input  wire rtca_pwr_t   power_state_in,
	input  wire logic        secure_clock_keepalive_in,
	input  wire logic        clock_disable_bit_in,
	input  wire rtca_cal_t   cal_in,
	input  wire logic        alarm_write_in,
	input  wire rtca_time_t  alarm_in,
	input  wire logic        alarm_irq_mask_in,
	input  wire logic        one_second_irq_mask_in,
	input  wire logic        time_write_in,
	input  wire rtca_time_t  time_in,
	input  wire logic        clear_one_second_in,
	input  wire logic        clear_alarm_in,
	input  wire logic        clear_contents_lost_in,
	output rtca_time_t       time_out,
	output rtca_time_t       alarm_out,
	output logic             alarm_irq_mask_out,
	output logic             one_second_irq_flag_out,
	output logic             alarm_irq_flag_out,
	output logic             contents_lost_irq_flag_out,
	output logic             irq_out,
	output logic             turn_on_out,
	output logic             processor_clock_enable_out,
	output logic             secure_clock_supply_enable_out,
	output logic             peripheral_clock_enable_out,
	output logic             cal_active_out
);

	////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisers
	logic rst_meta;
	logic rst_sync_n;
	logic por_n;
	logic bat_ok;
	logic bkp_only;

	// Reset enters asynchronously but is released on the clock
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_meta   <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta   <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// Clock reset and supply status come from other domains
	rtca_sync u_sync_por (
		.clk_in   (clk_in),
		.rst_n_in (rst_sync_n),
		.d_in     (clock_power_on_reset_n_in),
		.q_out    (por_n)
	);

	rtca_sync u_sync_bat (
		.clk_in   (clk_in),
		.rst_n_in (rst_sync_n),
		.d_in     (main_battery_ok_in),
		.q_out    (bat_ok)
	);

	rtca_sync u_sync_bkp (
		.clk_in   (clk_in),
		.rst_n_in (rst_sync_n),
		.d_in     (backup_only_in),
		.q_out    (bkp_only)
	);

	////////////////////////////////////////////////////////////////////////
	// Time base step from the system clock
	logic [12:0] base_cnt;
	logic [12:0] next_base_cnt;
	logic        base_step;
	logic        next_base_step;
	logic        tick;
	logic        cal_on;

	// Step period truncates the clock ratio, so seconds run slightly short
	always_comb begin
		next_base_step = 1'b0;
		next_base_cnt  = 13'(base_cnt + 13'h0001);
		if (base_cnt >= TICK_DIV_LAST) begin
			next_base_cnt  = 13'h0000;
			next_base_step = 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			base_cnt  <= 13'h0000;
			base_step <= 1'b0;
		end else begin
			base_cnt  <= next_base_cnt;
			base_step <= next_base_step;
		end
	end

	// Reserved mode 10 falls to the default and stays off
	always_comb begin
		case (cal_in.mode)
			RTCA_CAL_ALL:  cal_on = 1'b1;
			RTCA_CAL_MAIN: cal_on = bat_ok && !bkp_only;
			default:       cal_on = 1'b0;
		endcase
	end

	// The time base output itself is never trimmed
	rtca_divider u_div (
		.clk_in      (clk_in),
		.rst_n_in    (rst_sync_n),
		.step_in     (base_step),
		.run_in      (por_n && !clock_disable_bit_in),
		.cal_on_in   (cal_on),
		.cal_word_in (cal_in.word),
		.tick_out    (tick)
	);

	////////////////////////////////////////////////////////////////////////
	// Counters, alarm and flags
	rtca_time_t now;
	rtca_time_t next_now;
	rtca_time_t alarm;
	rtca_time_t next_alarm;
	logic       amask;
	logic       next_amask;
	logic       f_sec;
	logic       next_f_sec;
	logic       f_alm;
	logic       next_f_alm;
	logic       f_lost;
	logic       next_f_lost;
	logic       next_irq;
	logic       next_turn_on;
	logic       match;
	logic       match_d;
	logic       match_rise;

	// Edge detect starts high so the reset alarm value cannot flag at once
	assign match      = (now == alarm);
	assign match_rise = match && !match_d;

	always_comb begin
		next_now     = now;
		next_alarm   = alarm;
		next_amask   = amask;
		next_f_sec   = f_sec && !clear_one_second_in;
		next_f_alm   = f_alm && !clear_alarm_in;
		next_f_lost  = f_lost && !clear_contents_lost_in;
		next_turn_on = 1'b0;
		// Clears come first so a set in the same cycle wins
		// Writes are refused while the clock reset holds
		if (!por_n) begin
			next_now    = '{seconds: SEC_RST, day: DAY_RST};
			next_alarm  = '{seconds: ALARM_SEC_RST,
				day: ALARM_DAY_RST};
			next_amask  = 1'b1;
			next_f_sec  = 1'b0;
			next_f_alm  = 1'b0;
			next_f_lost = 1'b1;
		end else begin
			// Alarm mask follows its input outside the clock reset
			next_amask = alarm_irq_mask_in;
			if (alarm_write_in) begin
				next_alarm = alarm_in;
			end
			if (time_write_in) begin
				next_now = time_in;
			end else if (tick) begin
				next_f_sec = 1'b1;
				if (now.seconds >= SEC_MAX) begin
					next_now.seconds = SEC_RST;
					next_now.day = 15'(now.day + 15'h0001);
				end else begin
					next_now.seconds = 17'(now.seconds + 17'h00001);
				end
			end
			if (match_rise) begin
				next_f_alm = 1'b1;
				if (!amask && power_state_in != RTCA_PWR_ON) begin
					next_turn_on = 1'b1;
				end
			end
		end
		// Interrupt level follows the flags and masks one cycle later
		next_irq = (f_sec && !one_second_irq_mask_in) ||
			(f_alm && !amask && power_state_in == RTCA_PWR_ON);
	end

	always_ff @(posedge clk_in or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			now     <= '{seconds: SEC_RST, day: DAY_RST};
			alarm   <= '{seconds: ALARM_SEC_RST, day: ALARM_DAY_RST};
			amask   <= 1'b1;
			f_sec   <= 1'b0;
			f_alm   <= 1'b0;
			f_lost  <= 1'b1;
			match_d <= 1'b1;
			irq_out <= 1'b0;
			turn_on_out <= 1'b0;
		end else begin
			now     <= next_now;
			alarm   <= next_alarm;
			amask   <= next_amask;
			f_sec   <= next_f_sec;
			f_alm   <= next_f_alm;
			f_lost  <= next_f_lost;
			match_d <= match;
			irq_out <= next_irq;
			turn_on_out <= next_turn_on;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output registers and clock driver enables
	rtca_time_t next_time_out;
	rtca_time_t next_alarm_out;
	logic       next_amask_out;
	logic       next_f_sec_out;
	logic       next_f_alm_out;
	logic       next_f_lost_out;
	logic       next_pclk;
	logic       next_supply;
	logic       next_periph;
	logic       next_cal_active;

	// Keepalive overrides the power state decode of the processor clock
	always_comb begin
		next_time_out   = now;
		next_alarm_out  = alarm;
		next_amask_out  = amask;
		next_f_sec_out  = f_sec;
		next_f_alm_out  = f_alm;
		next_f_lost_out = f_lost;
		case (power_state_in)
			RTCA_PWR_OFF: next_pclk = secure_clock_keepalive_in;
			default:      next_pclk = 1'b1;
		endcase
		if (secure_clock_keepalive_in) begin
			next_pclk = 1'b1;
		end
		// Supply has no disable path once out of reset
		next_supply     = 1'b1;
		next_periph     = (power_state_in == RTCA_PWR_ON);
		next_cal_active = cal_on;
	end

	always_ff @(posedge clk_in or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			time_out   <= '{seconds: SEC_RST, day: DAY_RST};
			alarm_out  <= '{seconds: ALARM_SEC_RST, day: ALARM_DAY_RST};
			alarm_irq_mask_out             <= 1'b1;
			one_second_irq_flag_out        <= 1'b0;
			alarm_irq_flag_out             <= 1'b0;
			contents_lost_irq_flag_out     <= 1'b1;
			processor_clock_enable_out     <= 1'b1;
			secure_clock_supply_enable_out <= 1'b1;
			peripheral_clock_enable_out    <= 1'b0;
			cal_active_out                 <= 1'b0;
		end else begin
			time_out   <= next_time_out;
			alarm_out  <= next_alarm_out;
			alarm_irq_mask_out             <= next_amask_out;
			one_second_irq_flag_out        <= next_f_sec_out;
			alarm_irq_flag_out             <= next_f_alm_out;
			contents_lost_irq_flag_out     <= next_f_lost_out;
			processor_clock_enable_out     <= next_pclk;
			secure_clock_supply_enable_out <= next_supply;
			peripheral_clock_enable_out    <= next_periph;
			cal_active_out                 <= next_cal_active;
		end
	end

endmodule // rtca_core

// ==== bench/rtca_core_asserts.sv ====
// Checker for the real time clock core ports
`timescale 1ns/1ps
module rtca_core_asserts import rtca_pkg::*; (
	input wire logic       clk_in,
	input wire logic       rst_n_in,
	input wire logic       clock_power_on_reset_n_in,
	input wire logic       main_battery_ok_in,
	input wire logic       backup_only_in,
	input wire rtca_pwr_t  power_state_in,
	input wire logic       secure_clock_keepalive_in,
	input wire rtca_cal_t  cal_in,
	input wire rtca_time_t alarm_out,
	input wire logic       alarm_irq_mask_out,
	input wire logic       one_second_irq_flag_out,
	input wire logic       alarm_irq_flag_out,
	input wire logic       contents_lost_irq_flag_out,
	input wire logic       irq_out,
	input wire logic       turn_on_out,
	input wire logic       processor_clock_enable_out,
	input wire logic       secure_clock_supply_enable_out,
	input wire logic       cal_active_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	supply_on_a: assert property (secure_clock_supply_enable_out)
		else $error("secure supply off");
	keep_on_a: assert property (secure_clock_keepalive_in[*3]
		|-> processor_clock_enable_out) else $error("keepalive lost");
	off_stop_a: assert property ((!secure_clock_keepalive_in
		&& power_state_in == RTCA_PWR_OFF)[*5]
		|-> !processor_clock_enable_out) else $error("clock kept in off");
	mask_reset_a: assert property ($rose(rst_n_in)
		|-> alarm_irq_mask_out) else $error("mask not set");
	alarm_masked_a: assert property (alarm_irq_mask_out
		&& !one_second_irq_flag_out |-> !irq_out) else $error("masked irq");
	turn_on_flag_a: assert property (turn_on_out
		|-> ##[0:2] alarm_irq_flag_out) else $error("turn on w/o flag");
	cal_all_a: assert property ((cal_in.mode == RTCA_CAL_ALL
		&& clock_power_on_reset_n_in)[*6] |-> cal_active_out)
		else $error("cal not active");
	cal_main_a: assert property ((cal_in.mode == RTCA_CAL_MAIN
		&& (!main_battery_ok_in || backup_only_in))[*5] |-> !cal_active_out)
		else $error("cal active on backup");
	lost_set_a: assert property ((!clock_power_on_reset_n_in)[*5]
		|-> contents_lost_irq_flag_out && alarm_irq_mask_out
		&& alarm_out == {ALARM_SEC_RST, ALARM_DAY_RST})
		else $error("clock reset incomplete");
	cover property (turn_on_out);
	cover property (irq_out);
	cover property (cal_active_out);
endmodule // rtca_core_asserts

// ==== bench/rtca_host_model.sv ====
// Host processor model turning alarm wake requests into key presses
`timescale 1ns/1ps
module rtca_host_model (
	input  wire logic  clk_in,
	input  wire logic  rst_n_in,
	input  wire logic  turn_on_in,
	output logic       power_key_pull_out,
	output logic [7:0] wakes_out
);
	// Key pull looks like a press, so the host counts the cause itself
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			power_key_pull_out <= 1'b0;
			wakes_out <= 8'h00;
		end else begin
			power_key_pull_out <= turn_on_in;
			wakes_out <= wakes_out + 8'(turn_on_in);
		end
	end
endmodule // rtca_host_model

// ==== bench/tb_rtca_core.sv ====
// Testbench for the real time clock core
`timescale 1ns/1ps
module tb_rtca_core import rtca_pkg::*;;
	logic clk_in, rst_n_in, clock_power_on_reset_n_in, main_battery_ok_in;
	logic backup_only_in, secure_clock_keepalive_in, clock_disable_bit_in;
	logic alarm_write_in, alarm_irq_mask_in, one_second_irq_mask_in;
	logic time_write_in, clear_one_second_in, clear_alarm_in, irq_out;
	logic clear_contents_lost_in, alarm_irq_mask_out, one_second_irq_flag_out;
	logic alarm_irq_flag_out, contents_lost_irq_flag_out, turn_on_out;
	logic processor_clock_enable_out, secure_clock_supply_enable_out;
	logic peripheral_clock_enable_out, cal_active_out, key_pull, hit, m, on;
	rtca_pwr_t  power_state_in;
	rtca_cal_t  cal_in;
	rtca_time_t alarm_in, time_in, time_out, alarm_out;
	logic [7:0]  wakes, wk;
	logic [16:0] s;
	logic [14:0] d;
	integer seed, n_mismatch, checks, i;
	rtca_core rtca_core_inst (.*);
	rtca_host_model rtca_host_model_inst (.clk_in(clk_in),
		.rst_n_in(rst_n_in), .turn_on_in(turn_on_out),
		.power_key_pull_out(key_pull), .wakes_out(wakes));
	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic end_sim;
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	function automatic logic exp_cal(input logic [3:0] c);
		return c[3:2] == 2'h3 || (c[3:2] == 2'h1 && c[1] && !c[0]);
	endfunction
	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end
	initial begin
		#20000 n_mismatch++;
		end_sim;
	end
	initial begin
		seed = 48825;
		n_mismatch = 0;
		checks = 0;
		wk = 8'h00;
		{rst_n_in, clock_power_on_reset_n_in, main_battery_ok_in} = 3'h3;
		{backup_only_in, secure_clock_keepalive_in, time_write_in} = 3'h0;
		{clock_disable_bit_in, alarm_write_in, clear_one_second_in} = 3'h0;
		{clear_alarm_in, clear_contents_lost_in, alarm_irq_mask_in} = 3'h1;
		one_second_irq_mask_in = 1'b1;
		power_state_in = RTCA_PWR_ON;
		cal_in = '0;
		alarm_in = '0;
		time_in = '0;
		cyc(3);
		rst_n_in <= 1'b1;
		cyc(6);
		chk({ALARM_SEC_RST, ALARM_DAY_RST}, alarm_out);
		chk(32'h7, {alarm_irq_mask_out, contents_lost_irq_flag_out,
			secure_clock_supply_enable_out});
		clear_contents_lost_in <= 1'b1;
		cyc(1);
		clear_contents_lost_in <= 1'b0;
		cyc(4);
		chk(32'h0, contents_lost_irq_flag_out);
		for (i = 0; i < 10; i++) begin
			s = (i == 0) ? SEC_MAX : 17'($unsigned($random(seed)) % 86400);
			d = (i == 0) ? 15'h7FFF : 15'($random(seed));
			{m, on} = (i < 4) ? 2'(i) : 2'($random(seed));
			hit = i % 3 != 2;
			clock_disable_bit_in <= 1'($random(seed));
			alarm_irq_mask_in <= m;
			power_state_in <= on ? RTCA_PWR_ON : RTCA_PWR_OFF;
			alarm_in <= {s, d};
			alarm_write_in <= 1'b1;
			cyc(1);
			alarm_write_in <= 1'b0;
			time_in <= {s ^ 17'(!hit), d};
			time_write_in <= 1'b1;
			cyc(1);
			time_write_in <= 1'b0;
			cyc(5);
			wk = wk + 8'(hit & !m & !on);
			chk(32'(hit), alarm_irq_flag_out);
			chk(32'(hit & !m & on), irq_out);
			chk(32'(wk), 32'(wakes));
			chk({s, d}, alarm_out);
			chk({s ^ 17'(!hit), d}, time_out);
			chk(32'h0, one_second_irq_flag_out);
			{clear_alarm_in, clear_one_second_in} <= 2'h3;
			cyc(1);
			{clear_alarm_in, clear_one_second_in} <= 2'h0;
		end
		for (i = 0; i < 16; i++) begin
			cal_in <= {5'($random(seed)), 2'(i >> 2)};
			{main_battery_ok_in, backup_only_in} <= 2'(i);
			cyc(6);
			chk(32'(exp_cal(4'(i))), cal_active_out);
		end
		for (i = 0; i < 6; i++) begin
			secure_clock_keepalive_in <= i[0];
			power_state_in <= rtca_pwr_t'(i >> 1);
			cyc(5);
			if (i[0] || i < 2)
				chk(32'(i[0]), processor_clock_enable_out);
			chk(32'(i >> 1 == 2), peripheral_clock_enable_out);
		end
		alarm_irq_mask_in <= 1'b0;
		clock_power_on_reset_n_in <= 1'b0;
		cyc(6);
		chk({ALARM_SEC_RST, ALARM_DAY_RST}, alarm_out);
		chk({SEC_RST, DAY_RST}, time_out);
		chk(32'h3, {alarm_irq_mask_out, contents_lost_irq_flag_out});
		clock_power_on_reset_n_in <= 1'b1;
		cyc(6);
		end_sim;
	end
endmodule // tb_rtca_core
bind rtca_core rtca_core_asserts rtca_core_asserts_inst (
	.clk_in                         (clk_in),
	.rst_n_in                       (rst_n_in),
	.clock_power_on_reset_n_in      (clock_power_on_reset_n_in),
	.main_battery_ok_in             (main_battery_ok_in),
	.backup_only_in                 (backup_only_in),
	.power_state_in                 (power_state_in),
	.secure_clock_keepalive_in      (secure_clock_keepalive_in),
	.cal_in                         (cal_in),
	.alarm_out                      (alarm_out),
	.alarm_irq_mask_out             (alarm_irq_mask_out),
	.one_second_irq_flag_out        (one_second_irq_flag_out),
	.alarm_irq_flag_out             (alarm_irq_flag_out),
	.contents_lost_irq_flag_out     (contents_lost_irq_flag_out),
	.irq_out                        (irq_out),
	.turn_on_out                    (turn_on_out),
	.processor_clock_enable_out     (processor_clock_enable_out),
	.secure_clock_supply_enable_out (secure_clock_supply_enable_out),
	.cal_active_out                 (cal_active_out)
);
